/* File: verilog/tacl_defs.svh */
`ifndef TACL_DEFS_SVH
`define TACL_DEFS_SVH

// Command bytes
`define TACL_CMD_RD_TEMP_LO    8'h81
`define TACL_CMD_RD_TEMP_HI    8'h83
`define TACL_CMD_RD_STATUS     8'h85
`define TACL_CMD_RD_CFG        8'h87
`define TACL_CMD_WR_CFG        8'h92
`define TACL_CMD_RD_RATE       8'h89
`define TACL_CMD_WR_RATE       8'h94
`define TACL_CMD_RD_OT_LIMIT   8'ha1
`define TACL_CMD_WR_OT_LIMIT   8'ha4
`define TACL_CMD_RD_OT_RELEASE 8'ha3
`define TACL_CMD_WR_OT_RELEASE 8'ha6
`define TACL_CMD_RD_HIGH       8'h8f
`define TACL_CMD_WR_HIGH       8'h9a
`define TACL_CMD_RD_LOW        8'h91
`define TACL_CMD_WR_LOW        8'h9c
`define TACL_CMD_ONE_SHOT      8'h9e
`define TACL_CMD_RD_FSC        8'hab
`define TACL_CMD_WR_FSC        8'hb4
`define TACL_CMD_RD_GAIN       8'had
`define TACL_CMD_WR_GAIN       8'hb6

// Reset values
`define TACL_RST_CFG           8'h00
`define TACL_RST_RATE          8'h02
`define TACL_RST_OT_LIMIT      8'h64
`define TACL_RST_OT_RELEASE    8'h5f
`define TACL_RST_HIGH          8'h7f
`define TACL_RST_LOW           8'hc9
`define TACL_RST_FSC           8'h00
`define TACL_RST_GAIN          8'h80
`define TACL_FAULT_HIGH_BYTE   8'h80

// Configuration bits
`define TACL_CFG_ALERT_MASK    7
`define TACL_CFG_STANDBY       6
`define TACL_CFG_OT_POL        5
`define TACL_CFG_WPROT         4
`define TACL_CFG_OPEN_LOOP     3
`define TACL_CFG_OT_IN_INH     2
`define TACL_CFG_OT_OUT_MASK   1
`define TACL_CFG_WP_FIELD      8'h78
`define TACL_GAIN_OPEN_LOOP    0

// Status bits
`define TACL_ST_ALERT          6
`define TACL_ST_HIGH           4
`define TACL_ST_LOW            3
`define TACL_ST_OPEN           2
`define TACL_ST_OVERTEMP       1
`define TACL_ST_CLR_FIELD      8'h7c

// Timing
`define TACL_CLK_HZ            40000000
`define TACL_CONV_PERIOD_MS    500
`define TACL_CONV_CYCLES       ((`TACL_CLK_HZ / 1000) * `TACL_CONV_PERIOD_MS)
`define TACL_FRAC_BITS         3'h0

`endif

/* File: verilog/tacl_pkg.sv */
package tacl_pkg;

	typedef enum logic [0:0] {
		TACL_IDLE = 1'b0,
		TACL_CONV = 1'b1
	} tacl_conv_state_t;

	typedef struct packed {
		tacl_conv_state_t conv;
		logic [24:0]      timer;
		logic             start;
		logic [7:0]       cfg;
		logic [7:0]       rate;
		logic [7:0]       ot_limit;
		logic [7:0]       ot_release;
		logic [7:0]       high_lim;
		logic [7:0]       low_lim;
		logic [7:0]       fan_speed_word;
		logic [7:0]       gain;
		logic [7:0]       temp_hi;
		logic [7:0]       temp_lo;
		logic [7:0]       status;
		logic             ot_active;
		logic             alert;
		logic             ot_pin;
		logic             ot_oe;
		logic             fan_full;
		logic [7:0]       rdata;
		logic [1:0]       ot_sync;
	} tacl_state_t;

endpackage

/* File: verilog/tacl_core.sv */
`timescale 1ns/10ps
`include "tacl_defs.svh"

module tacl_core #(
	parameter int unsigned CONV_CYCLES = `TACL_CONV_CYCLES
) (
	input  wire logic        ref_clk_in,
	input  wire logic        srst_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic        cmd_strobe_in,
	input  wire logic [7:0]  reg_cmd_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        conv_done_in,
	input  wire logic [10:0] conv_temp_in,
	input  wire logic        diode_open_in,
	input  wire logic        diode_short_in,
	input  wire logic [7:0]  fan_speed_calc_in,
	input  wire logic        overtemp_pin_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             conv_start_out,
	output logic             conv_busy_out,
	output logic             overtemp_output_out,
	output logic             overtemp_oe_out,
	output logic             alert_oe_out,
	output logic             fan_full_out,
	output logic      [7:0]  fan_speed_word_out,
	output logic      [7:0]  fan_gain_out,
	output logic      [7:0]  conv_rate_out
);
	import tacl_pkg::*;

	tacl_state_t s_q;
	tacl_state_t s_d;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic               ot_int;
		logic               ot_ext;
		logic               wp;
		logic               is_done;
		logic               fault;
		logic signed [10:0] t;
		logic [7:0]         cause;
		ot_int  = 1'b0;
		ot_ext  = 1'b0;
		wp      = 1'b0;
		is_done = 1'b0;
		fault   = 1'b0;
		t       = 11'sh000;
		cause   = 8'h00;
		s_d     = s_q;
		s_d.start = 1'b0;
		// While we drive the pin the synchroniser is held idle, so our own low level
		// is never taken for an external one once the driver lets go
		s_d.ot_sync = s_q.ot_oe ? 2'h3 : {s_q.ot_sync[0], overtemp_pin_in};
		wp = s_q.cfg[`TACL_CFG_WPROT];

		// ****************************************
		// Conversion sequencing
		// ****************************************
		is_done = (s_q.conv == TACL_CONV) && conv_done_in;
		case (s_q.conv)
			TACL_IDLE: begin
				if (cmd_strobe_in && reg_cmd_in == `TACL_CMD_ONE_SHOT) begin
					s_d.conv  = TACL_CONV;
					s_d.start = 1'b1;
					s_d.timer = 25'h0;
				end else if (!s_q.cfg[`TACL_CFG_STANDBY]) begin
					if (s_q.timer >= 25'(CONV_CYCLES - 1)) begin
						s_d.conv  = TACL_CONV;
						s_d.start = 1'b1;
						s_d.timer = 25'h0;
					end else begin
						s_d.timer = s_q.timer + 25'h1;
					end
				end
			end
			TACL_CONV: begin
				// One-shot commands fall through unseen here
				if (!s_q.cfg[`TACL_CFG_STANDBY] && s_q.timer < 25'(CONV_CYCLES - 1)) begin
					s_d.timer = s_q.timer + 25'h1;
				end
				if (conv_done_in) begin
					s_d.conv = TACL_IDLE;
				end
			end
			default: begin
				s_d.conv = TACL_IDLE;
			end
		endcase

		// ****************************************
		// Result, limits and alert
		// ****************************************
		// The result is taken regardless of alert, so reads stay live
		t     = signed'(conv_temp_in);
		fault = diode_open_in || diode_short_in;
		if (is_done) begin
			s_d.temp_hi = fault ? `TACL_FAULT_HIGH_BYTE : conv_temp_in[10:3];
			s_d.temp_lo = fault ? 8'h00 : {conv_temp_in[2:0], 5'h00};
			if (!fault) begin
				if (t >= signed'({s_q.ot_limit, `TACL_FRAC_BITS})) begin
					s_d.ot_active = 1'b1;
				end else if (t < signed'({s_q.ot_release, `TACL_FRAC_BITS})) begin
					s_d.ot_active = 1'b0;
				end
				cause[`TACL_ST_HIGH] = t >= signed'({s_q.high_lim, `TACL_FRAC_BITS});
				cause[`TACL_ST_LOW]  = t < signed'({s_q.low_lim, `TACL_FRAC_BITS});
			end
			cause[`TACL_ST_OPEN] = diode_open_in;
			if (!s_q.cfg[`TACL_CFG_OPEN_LOOP]) begin
				s_d.fan_speed_word = fan_speed_calc_in;
			end
		end

		// External drive seen only in active-low mode while we are not pulling
		ot_ext = !s_q.cfg[`TACL_CFG_OT_POL] && !s_q.ot_oe && !s_q.ot_sync[1];
		ot_int = s_d.ot_active && !s_q.cfg[`TACL_CFG_OT_OUT_MASK];
		s_d.fan_full = ot_ext;
		if (s_q.cfg[`TACL_CFG_OT_POL]) begin
			s_d.ot_oe  = 1'b1;
			s_d.ot_pin = ot_int;
		end else begin
			s_d.ot_oe  = ot_int;
			s_d.ot_pin = 1'b0;
		end

		// ****************************************
		// Status read clear, then sets which win
		// ****************************************
		if (reg_rd_in && reg_cmd_in == `TACL_CMD_RD_STATUS) begin
			s_d.status = s_q.status & ~`TACL_ST_CLR_FIELD;
			s_d.alert  = 1'b0;
		end
		if (is_done) begin
			// A shorted diode has no status bit of its own but still raises the alert
			if (!s_q.cfg[`TACL_CFG_ALERT_MASK] && (cause != 8'h00 || fault || s_d.ot_active)) begin
				s_d.alert = 1'b1;
			end
			s_d.status = s_d.status | cause;
		end
		// Bit 1 follows the line level; a status read never clears it
		s_d.status[`TACL_ST_OVERTEMP] = ot_int || (ot_ext && !s_q.cfg[`TACL_CFG_OT_IN_INH]);
		// External low latches the alert once, on its first synchronised cycle
		if (ot_ext && !s_q.fan_full && !s_q.cfg[`TACL_CFG_OT_IN_INH]) begin
			s_d.alert = 1'b1;
		end
		s_d.status[`TACL_ST_ALERT] = s_d.alert | (s_d.status[`TACL_ST_ALERT] & s_q.alert);

		// ****************************************
		// Register writes
		// ****************************************
		if (reg_wr_in) begin
			case (reg_cmd_in)
				`TACL_CMD_WR_CFG: begin
					if (wp) begin
						s_d.cfg = (reg_wdata_in & ~`TACL_CFG_WP_FIELD) |
						          (s_q.cfg & `TACL_CFG_WP_FIELD);
					end else begin
						s_d.cfg = reg_wdata_in;
					end
				end
				`TACL_CMD_WR_RATE: begin
					if (!wp) s_d.rate = reg_wdata_in;
				end
				`TACL_CMD_WR_OT_LIMIT: begin
					if (!wp) s_d.ot_limit = reg_wdata_in;
				end
				`TACL_CMD_WR_OT_RELEASE: begin
					if (!wp) s_d.ot_release = reg_wdata_in;
				end
				`TACL_CMD_WR_HIGH: begin
					s_d.high_lim = reg_wdata_in;
				end
				`TACL_CMD_WR_LOW: begin
					s_d.low_lim = reg_wdata_in;
				end
				`TACL_CMD_WR_FSC: begin
					// Closed loop owns the speed word; host write only in open loop
					if (s_q.cfg[`TACL_CFG_OPEN_LOOP]) s_d.fan_speed_word = reg_wdata_in;
				end
				`TACL_CMD_WR_GAIN: begin
					s_d.gain = reg_wdata_in;
					if (reg_wdata_in[`TACL_GAIN_OPEN_LOOP]) begin
						s_d.cfg[`TACL_CFG_OPEN_LOOP] = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Standby entered mid-conversion drops that conversion
		if (s_d.cfg[`TACL_CFG_STANDBY] && !s_q.cfg[`TACL_CFG_STANDBY] &&
		    s_q.conv == TACL_CONV && !conv_done_in) begin
			s_d.conv = TACL_IDLE;
		end

		// ****************************************
		// Read data
		// ****************************************
		if (reg_rd_in) begin
			case (reg_cmd_in)
				`TACL_CMD_RD_TEMP_LO:    s_d.rdata = s_q.temp_lo;
				`TACL_CMD_RD_TEMP_HI:    s_d.rdata = s_q.temp_hi;
				`TACL_CMD_RD_STATUS:     s_d.rdata = s_q.status;
				`TACL_CMD_RD_CFG:        s_d.rdata = s_q.cfg;
				`TACL_CMD_RD_RATE:       s_d.rdata = s_q.rate;
				`TACL_CMD_RD_OT_LIMIT:   s_d.rdata = s_q.ot_limit;
				`TACL_CMD_RD_OT_RELEASE: s_d.rdata = s_q.ot_release;
				`TACL_CMD_RD_HIGH:       s_d.rdata = s_q.high_lim;
				`TACL_CMD_RD_LOW:        s_d.rdata = s_q.low_lim;
				`TACL_CMD_RD_FSC:        s_d.rdata = s_q.fan_speed_word;
				`TACL_CMD_RD_GAIN:       s_d.rdata = s_q.gain;
				default:                 s_d.rdata = 8'h00;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			s_q            <= '0;
			s_q.conv       <= TACL_IDLE;
			s_q.cfg        <= `TACL_RST_CFG;
			s_q.rate       <= `TACL_RST_RATE;
			s_q.ot_limit   <= `TACL_RST_OT_LIMIT;
			s_q.ot_release <= `TACL_RST_OT_RELEASE;
			s_q.high_lim   <= `TACL_RST_HIGH;
			s_q.low_lim    <= `TACL_RST_LOW;
			s_q.fan_speed_word        <= `TACL_RST_FSC;
			s_q.gain       <= `TACL_RST_GAIN;
			s_q.status     <= 8'h00;
			s_q.ot_sync    <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_out       = s_q.rdata;
	assign conv_start_out      = s_q.start;
	assign conv_busy_out       = (s_q.conv == TACL_CONV);
	assign overtemp_output_out = s_q.ot_pin;
	assign overtemp_oe_out     = s_q.ot_oe;
	assign alert_oe_out        = s_q.alert;
	assign fan_full_out        = s_q.fan_full;
	assign fan_speed_word_out  = s_q.fan_speed_word;
	assign fan_gain_out        = s_q.gain;
	assign conv_rate_out       = s_q.rate;

endmodule

/* File: verif/tacl_checker.sv */
`timescale 1ns/10ps
module tacl_checker (
	input wire logic       ref_clk_in,
	input wire logic       srst_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic       cmd_strobe_in,
	input wire logic [7:0] reg_cmd_in,
	input wire logic       conv_done_in,
	input wire logic       overtemp_pin_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       conv_start_out,
	input wire logic       conv_busy_out,
	input wire logic       alert_oe_out,
	input wire logic       fan_full_out,
	input wire logic [7:0] fan_speed_word_out,
	input wire logic [7:0] conv_rate_out
);
	// ****
	// Port relations
	// ****
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in);

	shot_start_a:
		assert property (cmd_strobe_in && reg_cmd_in == 8'h9e && !conv_busy_out |=> conv_start_out) else $error("no start");
	shot_ignore_a:
		assert property (cmd_strobe_in && conv_busy_out && !conv_done_in |=> !conv_start_out) else $error("busy start");
	alert_hold_a:
		assert property ($fell(alert_oe_out) |-> $past(reg_rd_in) && $past(reg_cmd_in) == 8'h85) else $error("alert lost");
	// Pin low reaches the latch through the two-flop synchroniser
	alert_cause_a:
		assert property ($rose(alert_oe_out) |-> $past(conv_done_in) || !$past(overtemp_pin_in, 2)
			|| !$past(overtemp_pin_in, 3)) else $error("alert cause");
	busy_end_a:
		assert property ($fell(conv_busy_out) |-> $past(conv_done_in) || $past(reg_wr_in)) else $error("busy drop");
	temp_low_a:
		assert property (reg_rd_in && reg_cmd_in == 8'h81 |=> reg_rdata_out[4:0] == 5'h00) else $error("low byte");
	rate_wp_a:
		assert property (!$stable(conv_rate_out) |-> $past(reg_wr_in) && $past(reg_cmd_in) == 8'h94) else $error("rate");
	fan_hold_a:
		assert property (!$stable(fan_speed_word_out) |-> $past(conv_done_in) || $past(reg_wr_in)) else $error("fan");
	ext_fan_a:
		assert property ($rose(fan_full_out) |-> !$past(overtemp_pin_in, 2) || !$past(overtemp_pin_in, 3)) else $error("full");
endmodule

bind tacl_core tacl_checker chk_i (.ref_clk_in, .srst_in, .reg_wr_in, .reg_rd_in, .cmd_strobe_in, .reg_cmd_in,
	.conv_done_in, .overtemp_pin_in, .reg_rdata_out, .conv_start_out, .conv_busy_out, .alert_oe_out,
	.fan_full_out, .fan_speed_word_out, .conv_rate_out);

/* File: verif/tacl_host_model.sv */
`timescale 1ns/10ps
module tacl_host_model (
	input  wire logic       ref_clk_in,
	input  wire logic [7:0] reg_rdata_in,
	output logic            reg_wr_out,
	output logic            reg_rd_out,
	output logic            cmd_strobe_out,
	output logic      [7:0] reg_cmd_out,
	output logic      [7:0] reg_wdata_out
);
	initial begin
		{reg_wr_out, reg_rd_out, cmd_strobe_out} = 3'h0;
		reg_cmd_out = 8'h00;
		reg_wdata_out = 8'h00;
	end
	// ****
	// One decoded transfer; k 1 write, 2 read, 3 command
	// ****
	// Released lines carry the inverse so a stale byte never looks valid
	task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d, output logic [7:0] q);
		@(posedge ref_clk_in);
		{reg_wr_out, reg_rd_out, cmd_strobe_out} <= {k == 2'd1, k == 2'd2, k == 2'd3};
		reg_cmd_out <= c;
		reg_wdata_out <= d;
		@(posedge ref_clk_in);
		{reg_wr_out, reg_rd_out, cmd_strobe_out} <= 3'h0;
		reg_cmd_out <= ~c;
		reg_wdata_out <= ~d;
		@(negedge ref_clk_in);
		q = reg_rdata_in;
	endtask
endmodule

/* File: verif/tacl_core_tb.sv */
`timescale 1ns/10ps
module tacl_core_tb;
	logic        ref_clk_in, srst_in, conv_done_in, diode_open_in, diode_short_in, ext_low;
	logic [10:0] conv_temp_in;
	logic [7:0]  fan_speed_calc_in;
	logic        reg_wr_in, reg_rd_in, cmd_strobe_in, conv_start_out, conv_busy_out;
	logic        overtemp_output_out, overtemp_oe_out, alert_oe_out, fan_full_out;
	logic [7:0]  reg_cmd_in, reg_wdata_in, reg_rdata_out, fan_speed_word_out, fan_gain_out, conv_rate_out;
	int          n_fail = 0, checks_done = 0, cyc = 0, n_start = 0;
	logic [10:0] t25 = 11'h0c8;
	// Pull-up on the pin; the bench can force it low from outside
	wire         overtemp_pin_in = !ext_low && (overtemp_oe_out ? overtemp_output_out : 1'b1);

	tacl_core #(.CONV_CYCLES(64)) uut (.ref_clk_in, .srst_in, .reg_wr_in, .reg_rd_in, .cmd_strobe_in, .reg_cmd_in,
		.reg_wdata_in, .conv_done_in, .conv_temp_in, .diode_open_in, .diode_short_in, .fan_speed_calc_in,
		.overtemp_pin_in, .reg_rdata_out, .conv_start_out, .conv_busy_out, .overtemp_output_out, .overtemp_oe_out,
		.alert_oe_out, .fan_full_out, .fan_speed_word_out, .fan_gain_out, .conv_rate_out);
	tacl_host_model host (.ref_clk_in, .reg_rdata_in(reg_rdata_out), .reg_wr_out(reg_wr_in),
		.reg_rd_out(reg_rd_in), .cmd_strobe_out(cmd_strobe_in), .reg_cmd_out(reg_cmd_in), .reg_wdata_out(reg_wdata_in));

	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (conv_start_out === 1'b1) n_start <= n_start + 1;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	// ****
	// Shared tasks
	// ****
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic fl(input string n, input logic e, input logic g);
		ck(n, {7'h0, e}, {7'h0, g});
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] q;
		host.xfer(2'd1, c, d, q);
	endtask
	task automatic rd(input logic [7:0] c, input logic [7:0] e, input logic [7:0] m = 8'hff);
		logic [7:0] q;
		host.xfer(2'd2, c, 8'h00, q);
		ck($sformatf("reg %h", c), e, q & m);
	endtask
	task automatic shot();
		logic [7:0] q;
		host.xfer(2'd3, 8'h9e, 8'h00, q);
	endtask
	task automatic clr();
		rd(8'h85, 8'h00, 8'h83);
		rd(8'h85, 8'h00);
	endtask
	task automatic ext(input logic v);
		@(posedge ref_clk_in);
		ext_low <= v;
		repeat (5) @(negedge ref_clk_in);
	endtask
	// Converter stand-in: answers the running conversion, fault bits f = {short, open}
	task automatic conv(input logic [10:0] t, input logic [1:0] f = 2'b00);
		for (int i = 0; i < 300 && conv_busy_out !== 1'b1; i++) @(negedge ref_clk_in);
		repeat (3) @(posedge ref_clk_in);
		{conv_done_in, conv_temp_in, diode_short_in, diode_open_in} <= {1'b1, t, f};
		@(posedge ref_clk_in);
		{conv_done_in, conv_temp_in, diode_short_in, diode_open_in} <= {1'b0, ~t, ~f};
		@(negedge ref_clk_in);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		logic [7:0] c [9] = '{8'h87, 8'h89, 8'ha1, 8'ha3, 8'h8f, 8'h91, 8'hab, 8'had, 8'h85};
		logic [7:0] e [9] = '{8'h00, 8'h02, 8'h64, 8'h5f, 8'h7f, 8'hc9, 8'h00, 8'h80, 8'h00};
		for (int i = 0; i < 9; i++) rd(c[i], e[i]);
		$display("reset test end");
	endtask
	task automatic t_temp();
		logic [10:0] t [3] = '{11'h0c8, 11'h001, 11'h7ff};
		logic [7:0] h [3] = '{8'h19, 8'h00, 8'hff};
		logic [7:0] l [3] = '{8'h00, 8'h20, 8'he0};
		for (int i = 0; i < 3; i++) begin
			conv(t[i]);
			rd(8'h83, h[i]);
			rd(8'h81, l[i]);
		end
		conv(t25, 2'b01);
		rd(8'h83, 8'h80);
		rd(8'h85, 8'h44, 8'h44);
		conv(t25, 2'b10);
		rd(8'h83, 8'h80);
		fl("alert", 1'b1, alert_oe_out);
		conv(t25);
		clr();
		$display("temp test end");
	endtask
	task automatic t_alert();
		wr(8'h9a, 8'h1e);
		conv(11'h0f0);
		conv(t25);
		fl("alert", 1'b1, alert_oe_out);
		rd(8'h83, 8'h19);
		rd(8'h85, 8'h50);
		fl("alert", 1'b0, alert_oe_out);
		conv(11'h0f0);
		fl("alert", 1'b1, alert_oe_out);
		wr(8'h92, 8'h80);
		rd(8'h85, 8'h50);
		conv(11'h0f0);
		fl("alert", 1'b0, alert_oe_out);
		wr(8'h92, 8'h00);
		wr(8'h9a, 8'h7f);
		conv(t25);
		clr();
		$display("alert test end");
	endtask
	task automatic t_overtemp();
		wr(8'h92, 8'h20);
		conv(11'h320);
		fl("ot", 1'b1, overtemp_output_out);
		conv(11'h2f8);
		fl("ot", 1'b1, overtemp_output_out);
		conv(11'h2f0);
		fl("ot", 1'b0, overtemp_output_out);
		wr(8'h92, 8'h22);
		conv(11'h3e8);
		fl("ot", 1'b0, overtemp_output_out);
		conv(t25);
		wr(8'h92, 8'h00);
		@(negedge ref_clk_in);
		fl("ot oe", 1'b0, overtemp_oe_out);
		conv(11'h320);
		fl("ot oe", 1'b1, overtemp_oe_out);
		fl("ot", 1'b0, overtemp_output_out);
		fl("full", 1'b0, fan_full_out);
		conv(t25);
		fl("ot oe", 1'b0, overtemp_oe_out);
		clr();
		$display("overtemp test end");
	endtask
	task automatic t_external();
		ext(1'b1);
		fl("full", 1'b1, fan_full_out);
		rd(8'h85, 8'h42);
		ext(1'b0);
		rd(8'h85, 8'h00);
		wr(8'h92, 8'h04);
		ext(1'b1);
		rd(8'h85, 8'h00);
		ext(1'b0);
		wr(8'h92, 8'h00);
		$display("external test end");
	endtask
	task automatic t_oneshot();
		int s;
		wr(8'h92, 8'h40);
		s = n_start;
		repeat (150) @(negedge ref_clk_in);
		ck("starts", s[7:0], n_start[7:0]);
		shot();
		fl("busy", 1'b1, conv_busy_out);
		shot();
		conv(t25);
		repeat (150) @(negedge ref_clk_in);
		ck("starts", s[7:0] + 8'h01, n_start[7:0]);
		wr(8'h92, 8'h00);
		conv(t25);
		shot();
		fl("busy", 1'b1, conv_busy_out);
		$display("oneshot test end");
	endtask
	task automatic t_protect();
		wr(8'h94, 8'h07);
		wr(8'h92, 8'h10);
		wr(8'ha4, 8'h55);
		wr(8'h94, 8'h03);
		wr(8'h92, 8'hce);
		rd(8'h87, 8'h96);
		rd(8'ha1, 8'h64);
		ck("rate", 8'h07, conv_rate_out);
		wr(8'hb4, 8'h33);
		ck("fsc", 8'h5a, fan_speed_word_out);
		wr(8'hb6, 8'h81);
		ck("gain", 8'h81, fan_gain_out);
		rd(8'h87, 8'h9e);
		wr(8'hb4, 8'h33);
		@(posedge ref_clk_in);
		fan_speed_calc_in <= 8'ha5;
		conv(t25);
		ck("fsc", 8'h33, fan_speed_word_out);
		$display("protect test end");
	endtask

	initial begin
		{srst_in, conv_done_in, diode_open_in, diode_short_in, ext_low} = 5'b10100;
		conv_temp_in = 11'h000;
		fan_speed_calc_in = 8'h5a;
		repeat (6) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		t_reset();
		t_temp();
		t_alert();
		t_overtemp();
		t_external();
		t_oneshot();
		t_protect();
		summarize();
	end
endmodule
